// File: hdl/float_log_power_unit.sv
// Notes on behaviour
// - Log op gives log of src2, base src1
// - Base<=1 or argument<=0: error, code 2003
// - Natural log op gives ln of src1
// - Natural log of value<=0: error, code 2003
// - Power op raises src1 to src2
// - Power result too large sets overflow flag
// - Power result too small sets underflow flag
// - Overflow writes 7f7f0000 to destination
// - Underflow writes ff7f0000 to destination
// - Zero flag when stored result is zero
// - Log operands are 32-bit words held as 16-bit register half pairs
`timescale 1ns/1ps
`default_nettype none
module float_log_power_unit (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Flags
   output logic busy_out,
   output logic zero_result_flag_out,
   output logic underflow_flag_out,
   output logic overflow_flag_out,
   output logic operation_error_flag_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      flp_pkg::st_t st;
      flp_pkg::op_t op;
      logic [31:0] src1; // Base or single source
      logic [31:0] src2; // Argument or exponent
      logic [31:0] dest;
      logic [63:0] acc; // Remainder or mantissa
      logic [63:0] den; // Divisor or exponent k
      logic [63:0] quo; // Quotient or t
      logic [6:0] cnt;
      logic neg; // Quotient sign
      logic zero;
      logic unf;
      logic ovf;
      logic err; // Sticky, write one to clear
      logic [15:0] errc;
      logic [31:0] rdat;
      logic ack;
      logic l2_start;
      logic [31:0] l2_opnd;
      logic fin; // One cycle as result lands
   } state_t;
   state_t state_ff;
   state_t nxt_state;
   log2_if l2 ();
   logic access; // New bus cycle
   logic go; // Accepted command
   logic bad; // Operand check failed
   logic [63:0] lv; // Latest log2 answer
   logic [63:0] mag_a;
   logic [63:0] mag_b;
   logic [88:0] ln_prod;
   logic [63:0] t;
   logic [64:0] rem_sh;
   logic [24:0] corr;
   logic [37:0] lin;
   logic [50:0] eprod;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge into a 16-bit half
   function automatic logic [15:0] merge16(input logic [15:0] o,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   // Subnormals flush to zero, so count as not positive
   function automatic logic le_zero(input logic [31:0] x);
      le_zero = x[31] || (x[30:23] == 8'h00);
   endfunction

   function automatic logic le_one(input logic [31:0] x);
      le_one = x[31] || (x[30:0] <= flp_pkg::ONE_F);
   endfunction

   // Signed Q40.24 to float, truncating
   function automatic logic [31:0] to_float(input logic [63:0] v);
      logic [63:0] mag;
      logic [63:0] nrm;
      logic [7:0] p;
      mag = v[63] ? (~v + 64'h1) : v;
      p = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (mag[i]) begin
            p = 8'(i);
         end
      end
      nrm = mag << (8'd63 - p);
      to_float = (mag == 64'h0) ? 32'h0 : {v[63], p + 8'd103, nrm[62:40]};
   endfunction

   // Exponent times log2 of base, Q40.24, clamped
   function automatic logic [63:0] pow_t(input logic [63:0] la,
      input logic [31:0] b);
      logic [63:0] mag;
      logic [63:0] p;
      logic [95:0] w;
      logic signed [9:0] sh;
      logic [63:0] r;
      mag = la[63] ? (~la + 64'h1) : la;
      p = mag[39:0] * {1'b1, b[22:0]};
      sh = $signed({2'b00, b[30:23]}) - 10'sd127;
      w = 96'h0;
      r = 64'h0;
      if (b[30:23] == 8'h00 || mag == 64'h0) begin
         r = 64'h0;
      end else if (sh > 10'sd20) begin
         r = flp_pkg::T_CLAMP;
      end else if (sh >= 10'sd0) begin
         w = {32'h0, p} << sh;
         r = (w[95:23] > {9'h0, flp_pkg::T_CLAMP}) ? flp_pkg::T_CLAMP : w[86:23];
      end else begin
         w = {32'h0, p} >> (10'sd23 - sh);
         r = w[63:0];
      end
      pow_t = (la[63] ^ b[31]) ? (~r + 64'h1) : r;
   endfunction

   // ----------------------------------------
   // Logarithm engine
   // ----------------------------------------
   log2_engine u_log2 (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .lg(l2.engine)
   );
   assign l2.start = state_ff.l2_start;
   assign l2.operand = state_ff.l2_opnd;

   // ----------------------------------------
   // Outputs from flops, except busy_out, which is decoded from the state flops
   // ----------------------------------------
   assign wb_dat_out = state_ff.rdat;
   assign wb_ack_out = state_ff.ack;
   assign busy_out = (state_ff.st != flp_pkg::S_IDLE);
   assign zero_result_flag_out = state_ff.zero;
   assign underflow_flag_out = state_ff.unf;
   assign overflow_flag_out = state_ff.ovf;
   assign operation_error_flag_out = state_ff.err;

   // ----------------------------------------
   // Next state: bus, then sequencer
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.l2_start = 1'b0;
      nxt_state.fin = 1'b0;
      access = wb_cyc_in && wb_stb_in && !state_ff.ack;
      nxt_state.ack = access;
      go = 1'b0;
      bad = 1'b0;
      lv = l2.result;
      mag_a = lv[63] ? (~lv + 64'h1) : lv;
      mag_b = state_ff.den;
      ln_prod = $signed({{25{lv[63]}}, lv}) * $signed({65'h0, flp_pkg::LN2_Q24});
      t = pow_t(lv, state_ff.src2);
      rem_sh = {state_ff.acc, state_ff.quo[63]};
      lin = {24'h0, state_ff.quo[13:0]} * {14'h0, flp_pkg::LN2_Q24};
      corr = {1'b1, 10'h0, lin[37:24]};
      eprod = state_ff.acc[25:0] * {1'b1, flp_pkg::EXP2_TBL[state_ff.cnt[3:0]]};
      if (state_ff.cnt == flp_pkg::EXP_TBL_N) begin
         eprod = state_ff.acc[25:0] * corr;
      end
      // Read data, latched as the ack goes out
      if (access && !wb_we_in) begin
         if (wb_adr_in == flp_pkg::ADR_SRC1_LO) begin
            nxt_state.rdat = {16'h0, state_ff.src1[15:0]};
         end else if (wb_adr_in == flp_pkg::ADR_SRC1_HI) begin
            nxt_state.rdat = {16'h0, state_ff.src1[31:16]};
         end else if (wb_adr_in == flp_pkg::ADR_SRC2_LO) begin
            nxt_state.rdat = {16'h0, state_ff.src2[15:0]};
         end else if (wb_adr_in == flp_pkg::ADR_SRC2_HI) begin
            nxt_state.rdat = {16'h0, state_ff.src2[31:16]};
         end else if (wb_adr_in == flp_pkg::ADR_DEST_LO) begin
            nxt_state.rdat = {16'h0, state_ff.dest[15:0]};
         end else if (wb_adr_in == flp_pkg::ADR_DEST_HI) begin
            nxt_state.rdat = {16'h0, state_ff.dest[31:16]};
         end else if (wb_adr_in == flp_pkg::ADR_CMD) begin
            nxt_state.rdat = {30'h0, state_ff.op};
         end else if (wb_adr_in == flp_pkg::ADR_STATUS) begin
            nxt_state.rdat = {27'h0, state_ff.err, state_ff.ovf, state_ff.unf,
               state_ff.zero, busy_out};
         end else if (wb_adr_in == flp_pkg::ADR_ERRC) begin
            nxt_state.rdat = {16'h0, state_ff.errc};
         end else begin
            // Unmapped reads return zero
            nxt_state.rdat = 32'h0;
         end
      end
      // Writes; operand writes while busy are ignored
      if (access && wb_we_in) begin
         if (wb_adr_in == flp_pkg::ADR_SRC1_LO && !busy_out) begin
            nxt_state.src1[15:0] = merge16(state_ff.src1[15:0], wb_dat_in, wb_sel_in);
         end else if (wb_adr_in == flp_pkg::ADR_SRC1_HI && !busy_out) begin
            nxt_state.src1[31:16] = merge16(state_ff.src1[31:16], wb_dat_in, wb_sel_in);
         end else if (wb_adr_in == flp_pkg::ADR_SRC2_LO && !busy_out) begin
            nxt_state.src2[15:0] = merge16(state_ff.src2[15:0], wb_dat_in, wb_sel_in);
         end else if (wb_adr_in == flp_pkg::ADR_SRC2_HI && !busy_out) begin
            nxt_state.src2[31:16] = merge16(state_ff.src2[31:16], wb_dat_in, wb_sel_in);
         end else if (wb_adr_in == flp_pkg::ADR_CMD && wb_sel_in[0]) begin
            // Launch only from idle with a real opcode
            go = !busy_out && (wb_dat_in[1:0] != flp_pkg::OP_NONE);
         end else if (wb_adr_in == flp_pkg::ADR_STATUS && wb_sel_in[0]) begin
            // Error flag clears by writing one
            if (wb_dat_in[flp_pkg::ST_ERR]) begin
               nxt_state.err = 1'b0;
            end
         end else if (wb_adr_in == flp_pkg::ADR_ERRC) begin
            nxt_state.errc = merge16(state_ff.errc, wb_dat_in, wb_sel_in);
         end
      end
      // Sequencer
      case (state_ff.st)
         flp_pkg::S_IDLE: begin
            if (go) begin
               nxt_state.op = flp_pkg::op_t'(wb_dat_in[1:0]);
               if (wb_dat_in[1:0] == flp_pkg::OP_LOGB) begin
                  bad = le_one(state_ff.src1) || le_zero(state_ff.src2);
               end else begin
                  // Power base check covers an issuer that breaks
                  bad = le_zero(state_ff.src1);
               end
               if (bad) begin
                  // Not executed; set wins over a clear
                  nxt_state.err = 1'b1;
                  nxt_state.errc = flp_pkg::ERR_BAD_OPND;
               end else begin
                  nxt_state.l2_start = 1'b1;
                  nxt_state.l2_opnd = state_ff.src1;
                  nxt_state.st = flp_pkg::S_LOG1;
               end
            end
         end
         flp_pkg::S_LOG1: begin
            if (l2.done) begin
               if (state_ff.op == flp_pkg::OP_LN) begin
                  // ln x = log2 x times ln 2
                  nxt_state.dest = to_float(ln_prod[87:24]);
                  nxt_state.st = flp_pkg::S_IDLE;
                  nxt_state.fin = 1'b1;
               end else if (state_ff.op == flp_pkg::OP_LOGB) begin
                  // Keep log2 of base, then take argument
                  nxt_state.den = lv;
                  nxt_state.l2_start = 1'b1;
                  nxt_state.l2_opnd = state_ff.src2;
                  nxt_state.st = flp_pkg::S_LOG2;
               end else if ($signed(t) >= $signed(flp_pkg::T_MAX)) begin
                  nxt_state.dest = flp_pkg::OVF_WORD;
                  nxt_state.st = flp_pkg::S_IDLE;
                  nxt_state.fin = 1'b1;
               end else if ($signed(t) < $signed(flp_pkg::T_MIN)) begin
                  nxt_state.dest = flp_pkg::UNF_WORD;
                  nxt_state.st = flp_pkg::S_IDLE;
                  nxt_state.fin = 1'b1;
               end else begin
                  // 2^t: integer part to den, fraction kept in quo
                  nxt_state.den = {{24{t[63]}}, t[63:24]};
                  nxt_state.quo = t;
                  nxt_state.acc = 64'h0000_0000_0100_0000;
                  nxt_state.cnt = 7'h00;
                  nxt_state.st = flp_pkg::S_EXP;
               end
               // Flags describe the new result
               nxt_state.ovf = (state_ff.op == flp_pkg::OP_POW) && ($signed(t) >= $signed(flp_pkg::T_MAX));
               nxt_state.unf = (state_ff.op == flp_pkg::OP_POW) && ($signed(t) < $signed(flp_pkg::T_MIN));
            end
         end
         flp_pkg::S_LOG2: begin
            if (l2.done) begin
               // Divide magnitudes, sign fixed at the end
               mag_b = state_ff.den[63] ? (~state_ff.den + 64'h1) : state_ff.den;
               nxt_state.neg = lv[63] ^ state_ff.den[63];
               nxt_state.quo = {mag_a[39:0], 24'h0};
               nxt_state.den = mag_b;
               nxt_state.acc = 64'h0;
               nxt_state.cnt = 7'h00;
               nxt_state.st = flp_pkg::S_DIV;
            end
         end
         flp_pkg::S_DIV: begin
            // Restoring division, one bit per cycle
            if (rem_sh >= {1'b0, state_ff.den}) begin
               nxt_state.acc = 64'(rem_sh - {1'b0, state_ff.den});
               nxt_state.quo = {state_ff.quo[62:0], 1'b1};
            end else begin
               nxt_state.acc = rem_sh[63:0];
               nxt_state.quo = {state_ff.quo[62:0], 1'b0};
            end
            nxt_state.cnt = state_ff.cnt + 7'h01;
            if (state_ff.cnt == flp_pkg::DIV_LAST) begin
               nxt_state.dest = to_float(state_ff.neg ? (~nxt_state.quo + 64'h1) : nxt_state.quo);
               nxt_state.st = flp_pkg::S_IDLE;
               nxt_state.fin = 1'b1;
            end
         end
         flp_pkg::S_EXP: begin
            // Table factors for the top fraction bits, then linear tail
            if (state_ff.cnt < flp_pkg::EXP_TBL_N) begin
               if (state_ff.quo[5'd23 - state_ff.cnt[4:0]]) begin
                  nxt_state.acc = {38'h0, eprod[49:24]};
               end
               nxt_state.cnt = state_ff.cnt + 7'h01;
            end else begin
               nxt_state.st = flp_pkg::S_IDLE;
               nxt_state.fin = 1'b1;
               if (eprod[49]) begin
                  nxt_state.dest = {1'b0, 8'(state_ff.den[7:0] + 8'd128), eprod[48:26]};
               end else begin
                  nxt_state.dest = {1'b0, 8'(state_ff.den[7:0] + 8'd127), eprod[47:25]};
               end
            end
         end
         default: begin
            nxt_state.st = flp_pkg::S_IDLE;
         end
      endcase
      // Zero flag follows every stored result
      if (nxt_state.fin) begin
         nxt_state.zero = (nxt_state.dest == 32'h0);
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_log_bad;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      go && bad && (wb_dat_in[1:0] == flp_pkg::OP_LOGB) |=>
         state_ff.err && (state_ff.errc == flp_pkg::ERR_BAD_OPND) && !busy_out;
   endproperty
   a_log_bad: assert property (p_log_bad)
      else $error("bad log operand not flagged");
   property p_ln_bad;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      go && (wb_dat_in[1:0] == flp_pkg::OP_LN) && state_ff.src1[31] |=>
         state_ff.err ##1 !state_ff.fin [*8];
   endproperty
   a_ln_bad: assert property (p_ln_bad)
      else $error("negative ln operand executed");
   property p_ovf_word;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      state_ff.fin && state_ff.ovf |-> state_ff.dest == flp_pkg::OVF_WORD;
   endproperty
   a_ovf_word: assert property (p_ovf_word)
      else $error("overflow word wrong");
   property p_unf_word;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      state_ff.fin && state_ff.unf |-> state_ff.dest == flp_pkg::UNF_WORD;
   endproperty
   a_unf_word: assert property (p_unf_word)
      else $error("underflow word wrong");
   property p_ovf_pow;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(state_ff.ovf) |-> state_ff.fin && (state_ff.op == flp_pkg::OP_POW);
   endproperty
   a_ovf_pow: assert property (p_ovf_pow)
      else $error("overflow outside power result");
   property p_unf_pow;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(state_ff.unf) |-> state_ff.fin && (state_ff.op == flp_pkg::OP_POW);
   endproperty
   a_unf_pow: assert property (p_unf_pow)
      else $error("underflow outside power result");
   property p_zero_flag;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      state_ff.fin |-> state_ff.zero == (state_ff.dest == 32'h0);
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag disagrees with result");
   property p_done_bound;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      go && !bad |-> ##[2:200] state_ff.fin;
   endproperty
   a_done_bound: assert property (p_done_bound)
      else $error("operation did not finish");
   property p_dest_hi;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      wb_ack_out && !wb_we_in && (wb_adr_in == flp_pkg::ADR_DEST_HI) && !busy_out && !state_ff.fin
         |-> wb_dat_out == {16'h0, state_ff.dest[31:16]};
   endproperty
   a_dest_hi: assert property (p_dest_hi)
      else $error("high result half misread");
   c_ovf: cover property (@(posedge sys_clk_in) state_ff.fin && state_ff.ovf);
   c_unf: cover property (@(posedge sys_clk_in) state_ff.fin && state_ff.unf);
   c_err: cover property (@(posedge sys_clk_in) go && bad);
   c_zero: cover property (@(posedge sys_clk_in) state_ff.fin && state_ff.zero);
endmodule
`default_nettype wire

// File: hdl/flp_pkg.sv
package flp_pkg;
   // ----------------------------------------
   // Register byte offsets, one 16-bit half each
   // ----------------------------------------
   localparam logic [7:0] ADR_SRC1_LO = 8'h00;
   localparam logic [7:0] ADR_SRC1_HI = 8'h04;
   localparam logic [7:0] ADR_SRC2_LO = 8'h08;
   localparam logic [7:0] ADR_SRC2_HI = 8'h0c;
   localparam logic [7:0] ADR_DEST_LO = 8'h10;
   localparam logic [7:0] ADR_DEST_HI = 8'h14;
   localparam logic [7:0] ADR_CMD = 8'h18;
   localparam logic [7:0] ADR_STATUS = 8'h1c;
   localparam logic [7:0] ADR_ERRC = 8'h20;
   // ----------------------------------------
   // Status bit positions
   // ----------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_ZERO = 1;
   localparam int ST_UNF = 2;
   localparam int ST_OVF = 3;
   localparam int ST_ERR = 4;
   // ----------------------------------------
   // Values and reset values
   // ----------------------------------------
   localparam logic [15:0] HALF_RST = 16'h0000;
   localparam logic [15:0] ERR_BAD_OPND = 16'h2003;
   localparam logic [31:0] OVF_WORD = 32'h7f7f0000;
   localparam logic [31:0] UNF_WORD = 32'hff7f0000;
   localparam logic [30:0] ONE_F = 31'h3f800000;
   localparam logic [23:0] LN2_Q24 = 24'hb17218;
   localparam logic [63:0] T_MAX = 64'h0000_0000_8000_0000;
   localparam logic [63:0] T_MIN = 64'hffff_ffff_8200_0000;
   localparam logic [63:0] T_CLAMP = 64'h0000_0004_0000_0000;
   // ----------------------------------------
   // Step counts
   // ----------------------------------------
   localparam logic [4:0] LOG2_LAST = 5'h17;
   localparam logic [6:0] DIV_LAST = 7'h3f;
   localparam logic [6:0] EXP_TBL_N = 7'h0a;
   // Fractions of 2^(2^-(i+1)), entry 0 listed last
   localparam logic [9:0][23:0] EXP2_TBL = {
      24'h002c60, 24'h0058c8, 24'h00b1b0, 24'h0163db, 24'h02c9a4,
      24'h059b0d, 24'h0b5587, 24'h172b84, 24'h306fe0, 24'h6a09e6};
   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {OP_NONE = 2'b00, OP_LOGB = 2'b01,
      OP_LN = 2'b10, OP_POW = 2'b11} op_t;
   typedef enum logic [2:0] {S_IDLE = 3'b000, S_LOG1 = 3'b001,
      S_LOG2 = 3'b010, S_DIV = 3'b011, S_EXP = 3'b100} st_t;
endpackage

// File: hdl/log2_if.sv
`timescale 1ns/1ps
`default_nettype none
interface log2_if;
   logic start; // One-cycle launch
   logic [31:0] operand; // Positive normal float
   logic done; // One-cycle completion
   logic [63:0] result; // Signed Q40.24 log2
   modport engine(input start, input operand, output done, output result);
   modport client(output start, output operand, input done, input result);
endinterface
`default_nettype wire

// File: hdl/log2_engine.sv
`timescale 1ns/1ps
`default_nettype none
module log2_engine (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // Request and answer
   log2_if.engine lg
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic busy;
      logic [4:0] cnt;
      logic [23:0] m; // Mantissa being squared, Q1.23
      logic [23:0] frac; // Fraction bits so far
      logic [8:0] e; // Unbiased exponent
      logic done;
      logic [63:0] res;
   } lg_state_t;
   lg_state_t state_ff;
   lg_state_t nxt_state;
   logic [47:0] sq;
   logic b;

   assign lg.done = state_ff.done;
   assign lg.result = state_ff.res;

   // Squaring: one fraction bit per cycle, truncating each square, and slow
   always_comb begin
      nxt_state = state_ff;
      nxt_state.done = 1'b0;
      sq = state_ff.m * state_ff.m;
      b = sq[47];
      if (lg.start) begin
         nxt_state.busy = 1'b1;
         nxt_state.cnt = 5'h00;
         nxt_state.m = {1'b1, lg.operand[22:0]};
         nxt_state.frac = 24'h0;
         nxt_state.e = {1'b0, lg.operand[30:23]} - 9'd127;
      end else if (state_ff.busy) begin
         // Square at or above two: bit set, halve
         nxt_state.m = b ? sq[47:24] : sq[46:23];
         nxt_state.frac = {state_ff.frac[22:0], b};
         nxt_state.cnt = state_ff.cnt + 5'h01;
         if (state_ff.cnt == flp_pkg::LOG2_LAST) begin
            nxt_state.busy = 1'b0;
            nxt_state.done = 1'b1;
            nxt_state.res = {{31{state_ff.e[8]}}, state_ff.e, state_ff.frac[22:0], b};
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_log2_lat;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      lg.start |-> ##1 (!lg.done) [*8] ##17 lg.done;
   endproperty
   a_log2_lat: assert property (p_log2_lat)
      else $error("log2 answer not 25 cycles after start");
endmodule
`default_nettype wire

// File: verif/seq_master.sv
`timescale 1ns/1ps
`default_nettype none
// Sequencer side: classic Wishbone master
module seq_master (
   // Clock and answer
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [31:0] dat_in,
   // Request
   output logic cyc_out,
   output logic we_out,
   output logic [7:0] adr_out,
   output logic [31:0] dat_out
);
   // Idle bus from time zero
   initial begin
      cyc_out = 1'b0;
      we_out = 1'b0;
      adr_out = 8'h00;
      dat_out = 32'h0;
   end
   // Held until ack; the bench watchdog bounds a hang
   task xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_in);
      cyc_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      dat_out <= {16'h0, d};
      do @(posedge clk_in); while (ack_in !== 1'b1);
      q = dat_in[15:0];
      cyc_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verif/float_log_power_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module float_log_power_unit_test;
   logic sys_clk, rstn, cyc, we, ack, busy, zro, unf, ovf, err;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, res;
   logic [15:0] q;
   int miscompares = 0;
   int tests_run = 0;
   // Error cases: bad base, bad argument, negative log input
   logic [31:0] ea[3] = '{32'h3f800000, 32'h40000000, 32'hbf800000};
   logic [31:0] eb[3] = '{32'h41000000, 32'h0, 32'h0};
   logic [1:0] ec[3] = '{2'h1, 2'h1, 2'h2};
   float_log_power_unit float_log_power_unit_inst (.sys_clk_in(sys_clk), .rstn_in(rstn),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .busy_out(busy),
      .zero_result_flag_out(zro), .underflow_flag_out(unf), .overflow_flag_out(ovf),
      .operation_error_flag_out(err));
   seq_master seq_master_inst (.clk_in(sys_clk), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
      .we_out(we), .adr_out(adr), .dat_out(wdat));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Verdict and stop
   task end_sim;
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Window compare; truncated maths may sit a few units low
   task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] t);
      tests_run++;
      if (^g === 1'bx || (g + t - e) > 2 * t) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      seq_master_inst.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, output logic [15:0] v);
      seq_master_inst.xfer(1'b0, a, 16'h0, v);
   endtask
   // Load both sources as half pairs, launch, wait, fetch result
   task run(input logic [31:0] a, input logic [31:0] b, input logic [1:0] c);
      wr(flp_pkg::ADR_SRC1_LO, a[15:0]);
      wr(flp_pkg::ADR_SRC1_HI, a[31:16]);
      wr(flp_pkg::ADR_SRC2_LO, b[15:0]);
      wr(flp_pkg::ADR_SRC2_HI, b[31:16]);
      wr(flp_pkg::ADR_CMD, {14'h0, c});
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge sys_clk);
      // A wait that runs out counts as a mismatch
      chk(busy, 32'h0, 32'h0);
      rd(flp_pkg::ADR_DEST_LO, res[15:0]);
      rd(flp_pkg::ADR_DEST_HI, res[31:16]);
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      end_sim;
   end
   // -------------------------------
   // Test sequence
   // -------------------------------
   initial begin
      rstn = 1'b0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(flp_pkg::ADR_ERRC, q);
      chk(q, 32'h0, 32'h0);
      rd(8'h40, q);
      chk(q, 32'h0, 32'h0);
      run(32'h3f800000, 32'h0, 2'h2);
      chk(res, 32'h0, 32'h0);
      chk(zro, 32'h1, 32'h0);
      run(32'h40000000, 32'h41000000, 2'h1);
      chk(res, 32'h40400000, 32'h8);
      chk(zro, 32'h0, 32'h0);
      run(32'h40000000, 32'h40400000, 2'h3);
      chk(res, 32'h41000000, 32'h8);
      run(32'h40000000, 32'h43480000, 2'h3);
      chk(res, flp_pkg::OVF_WORD, 32'h0);
      chk(ovf, 32'h1, 32'h0);
      run(32'h40000000, 32'hc3480000, 2'h3);
      chk(res, flp_pkg::UNF_WORD, 32'h0);
      chk(unf, 32'h1, 32'h0);
      chk(ovf, 32'h0, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(flp_pkg::ADR_STATUS, 16'h0010);
         wr(flp_pkg::ADR_ERRC, 16'h0000);
         run(ea[i], eb[i], ec[i]);
         chk(err, 32'h1, 32'h0);
         rd(flp_pkg::ADR_ERRC, q);
         chk(q, 32'h2003, 32'h0);
         chk(res, flp_pkg::UNF_WORD, 32'h0);
      end
      end_sim;
   end
endmodule
`default_nettype wire
